// ### logic/ppp_pkg.sv
// package for the prom programming port: widths, address limits, mode enums
package ppp_pkg;
    localparam int           ADDR_W      = 14;
    localparam int           LOW_W       = 8;
    localparam int           HIGH_W      = ADDR_W - LOW_W;
    localparam int           DATA_W      = 8;
    localparam int           DEPTH       = 1 << ADDR_W;
    localparam int           PROG_CYCLES = 2;
    localparam logic [7:0]   ERASED      = 8'hFF;
    localparam logic [13:0]  USER_BASE   = 14'h1800;
    localparam logic [13:0]  USER_TOP    = 14'h3FFF;

    typedef enum logic [1:0] {
        PPP_IDLE  = 2'b00,
        PPP_READ  = 2'b01,
        PPP_PROG  = 2'b10,
        PPP_OFF   = 2'b11
    } ppp_mode_e;

    typedef struct packed {
        logic chip_en_n;
        logic out_en_n;
        logic program_strobe_n;
    } ppp_strobe_s;
endpackage : ppp_pkg

// ### logic/ppp_sync.sv
// two-flop synchroniser, one instance covers a whole W-bit bus
module ppp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule : ppp_sync

// ### logic/ppp_prom_port.sv
// prom programming port: pins in, prom array, data bus out
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ppp_prom_port (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        reset_pin_n,
    input  wire logic                        mode_select_pin,
    input  wire logic [ppp_pkg::LOW_W-1:0]   low_address_port,
    input  wire logic [ppp_pkg::HIGH_W-1:0]  high_address_port,
    input  wire logic [ppp_pkg::DATA_W-1:0]  prom_data_port_i,
    output logic      [ppp_pkg::DATA_W-1:0]  prom_data_port_o,
    output logic                             prom_data_port_oe,
    input  wire ppp_pkg::ppp_strobe_s        strobe_port,
    output logic                             prog_mode,
    output logic                             prog_busy
);
    // ---------------------------------------------------------------
    // local sizes and counts
    // ---------------------------------------------------------------
    localparam int               CTRL_W      = 2;
    localparam int               STB_W       = $bits(ppp_pkg::ppp_strobe_s);
    localparam int               SW          = CTRL_W + ppp_pkg::ADDR_W + ppp_pkg::DATA_W + STB_W;
    localparam int               SYNC_STAGES = 2;
    localparam int               CNT_W       = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO    = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_PROG    = CNT_W'(ppp_pkg::PROG_CYCLES);
    localparam logic [CNT_W-1:0] SETTLE_MAX  = CNT_W'(SYNC_STAGES);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] pins;

    assign raw_pins = {reset_pin_n, mode_select_pin, high_address_port, low_address_port,
                       prom_data_port_i, strobe_port};

    ppp_sync #(.W(SW)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     (raw_pins),
        .q     (pins)
    );

    logic                          rst_pin_n_s;
    logic                          vpp_s;
    logic [ppp_pkg::ADDR_W-1:0]    addr_s;
    logic [ppp_pkg::DATA_W-1:0]    din_s;
    ppp_pkg::ppp_strobe_s          stb_s;

    // address bits from both ports joined into one 14-bit word
    assign {rst_pin_n_s, vpp_s, addr_s, din_s, stb_s} = pins;

    // ---------------------------------------------------------------
    // settle window after reset
    // ---------------------------------------------------------------
    // sync flops clear to zero, which would read as a low reset pin;
    // hold the port at rest until real pin levels have come through
    logic [CNT_W-1:0] settle_cnt_q;
    logic [CNT_W-1:0] settle_cnt_d;
    logic             settled;

    always_comb begin
        settle_cnt_d = settle_cnt_q;
        if (settle_cnt_q != SETTLE_MAX) begin
            settle_cnt_d = settle_cnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            settle_cnt_q <= CNT_ZERO;
        end else begin
            settle_cnt_q <= settle_cnt_d;
        end
    end

    assign settled = (settle_cnt_q == SETTLE_MAX);

    // ---------------------------------------------------------------
    // address settle check
    // ---------------------------------------------------------------
    // address bits cross one by one, so a moving address can show a
    // mixed word for a cycle; read data only follows a steady address
    logic [ppp_pkg::ADDR_W-1:0] addr_prev_q;
    logic [ppp_pkg::ADDR_W-1:0] addr_prev_d;
    logic                       addr_steady;

    always_comb begin
        addr_prev_d = addr_s;
        addr_steady = (addr_s == addr_prev_q);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_prev_q <= '0;
        end else begin
            addr_prev_q <= addr_prev_d;
        end
    end

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    ppp_pkg::ppp_mode_e mode;

    always_comb begin
        if (!settled || rst_pin_n_s) begin
            mode = ppp_pkg::PPP_IDLE;
        end else if (stb_s.chip_en_n) begin
            mode = ppp_pkg::PPP_OFF;
        end else if (!stb_s.out_en_n && stb_s.program_strobe_n) begin
            mode = ppp_pkg::PPP_READ;
        end else if (stb_s.out_en_n && vpp_s) begin
            mode = ppp_pkg::PPP_PROG;
        end else begin
            mode = ppp_pkg::PPP_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // program pulse detection and array write
    // ---------------------------------------------------------------
    logic                        pgm_prev_q;
    logic                        pgm_prev_d;
    logic [CNT_W-1:0]            busy_cnt_q;
    logic [CNT_W-1:0]            busy_cnt_d;
    logic                        wr_en;
    logic [ppp_pkg::DATA_W-1:0]  mem [ppp_pkg::DEPTH];

    // store fires once on the falling edge, a held-low strobe writes nothing more
    assign wr_en = (mode == ppp_pkg::PPP_PROG) && pgm_prev_q && !stb_s.program_strobe_n;

    always_comb begin
        pgm_prev_d = stb_s.program_strobe_n;
        busy_cnt_d = busy_cnt_q;
        if (wr_en) begin
            busy_cnt_d = CNT_PROG;
        end else if (busy_cnt_q != CNT_ZERO) begin
            busy_cnt_d = busy_cnt_q - CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pgm_prev_q <= 1'b1;
            busy_cnt_q <= CNT_ZERO;
        end else begin
            pgm_prev_q <= pgm_prev_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // ---------------------------------------------------------------
    // one-time array cells
    // ---------------------------------------------------------------
    logic [ppp_pkg::DATA_W-1:0] cell_now;
    logic [ppp_pkg::DATA_W-1:0] cell_new;

    assign cell_now = mem[addr_s];

    // one-time prom: a write can only clear bits, never set them
    for (genvar b = 0; b < ppp_pkg::DATA_W; b++) begin : g_bit
        assign cell_new[b] = cell_now[b] & din_s[b];
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr_s] <= cell_new;
        end
    end

    // array starts erased; not reset so it stays a plain memory
    initial begin
        for (int i = 0; i < ppp_pkg::DEPTH; i++) begin
            mem[i] = ppp_pkg::ERASED;
        end
    end

    // ---------------------------------------------------------------
    // data bus output
    // ---------------------------------------------------------------
    logic [ppp_pkg::DATA_W-1:0] dout_d;
    logic                       oe_d;
    logic                       mode_d;
    logic                       busy_d;

    always_comb begin
        oe_d   = (mode == ppp_pkg::PPP_READ);
        dout_d = '0;
        if (oe_d && addr_steady) begin
            dout_d = cell_now;
        end else if (oe_d) begin
            dout_d = prom_data_port_o;
        end
        mode_d = settled && !rst_pin_n_s;
        busy_d = (busy_cnt_d != CNT_ZERO);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prom_data_port_o  <= '0;
            prom_data_port_oe <= 1'b0;
            prog_mode         <= 1'b0;
            prog_busy         <= 1'b0;
        end else begin
            prom_data_port_o  <= dout_d;
            prom_data_port_oe <= oe_d;
            prog_mode         <= mode_d;
            prog_busy         <= busy_d;
        end
    end
endmodule : ppp_prom_port

// ### dv/ppp_prom_port_monitor.sv
// checker on the prom programming port pins
module ppp_monitor (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 reset_pin_n,
    input wire logic                 mode_select_pin,
    input wire ppp_pkg::ppp_strobe_s strobe_port,
    input wire logic [7:0]           prom_data_port_o,
    input wire logic                 prom_data_port_oe,
    input wire logic                 prog_mode,
    input wire logic                 prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire c = strobe_port.chip_en_n;
    wire o = strobe_port.out_en_n;
    wire p = strobe_port.program_strobe_n;
    wire pm = !reset_pin_n;
    // four samples span both sync flops and the output register
    wire rd = pm & !c & !o & p;
    wire fl = !pm | c | o;
    chk_mode_on: assert property (pm [*4] |-> prog_mode) else $error("mode");
    chk_mode_off: assert property (!pm [*4] |-> !prog_mode) else $error("mode");
    chk_read_drive: assert property (rd [*4] |-> prom_data_port_oe) else $error("drive");
    chk_bus_float: assert property (fl [*4] |-> !prom_data_port_oe) else $error("float");
    chk_idle_zero: assert property (!prom_data_port_oe |-> prom_data_port_o == 8'h00) else $error("idle");
    chk_prog_start: assert property (pm && mode_select_pin && !c && o && $fell(p) |-> ##[3:5] prog_busy) else $error("prog");
    chk_busy_len: assert property ($rose(prog_busy) |=> prog_busy ##1 !prog_busy) else $error("busy");
    chk_no_vpp: assert property (!mode_select_pin [*8] |-> !prog_busy) else $error("vpp");
    cover property (rd [*4]);
    cover property ($rose(prog_busy));
    cover property (fl [*4] ##1 rd);
endmodule : ppp_monitor
bind ppp_prom_port ppp_monitor i_mon (.clk, .reset, .reset_pin_n, .mode_select_pin, .strobe_port,
    .prom_data_port_o, .prom_data_port_oe, .prog_mode, .prog_busy);

// ### dv/ppp_writer.sv
// prom writer model: drives address, data and strobes
module ppp_writer (
    input  wire logic            clk,
    input  wire logic [7:0]      dev_o,
    input  wire logic            dev_oe,
    input  wire logic            busy,
    output logic                 vpp  = 1'b0,
    output logic [13:0]          addr = 14'h0000,
    output logic [7:0]           bus,
    output ppp_pkg::ppp_strobe_s stb  = 3'b111
);
    timeunit 1ns;
    timeprecision 1ps;
    logic den = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last = 8'h00;
    // a released bus toggles so a stale byte never reads back
    assign bus = dev_oe ? dev_o : den ? wd : ~last;
    always @(posedge clk) last <= bus;
    task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic v, output logic ok);
        @(negedge clk) {vpp, addr, wd, den, stb, ok} = {v, a, d, 5'b10110};
        // the device lets go of the bus 3 edges late; data must then stand 3 more
        repeat (6) @(negedge clk);
        stb.program_strobe_n = 1'b0;
        repeat (8) @(negedge clk) ok |= busy;
        stb.program_strobe_n = 1'b1;
        repeat (3) @(negedge clk);
        den = 1'b0;
    endtask : wr
    task automatic rd(input logic [13:0] a, input logic [2:0] s, output logic [7:0] q, output logic oe);
        @(negedge clk) {addr, stb} = {a, s};
        repeat (5) @(negedge clk);
        {q, oe} = {bus, dev_oe};
    endtask : rd
endmodule : ppp_writer

// ### dv/tb_prom_programming_port.sv
// self-checking bench for the prom programming port
module tb_prom_programming_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, rp_n = 1'b0, vpp, doe, busy, mode, ok, oe;
    logic [13:0] addr;
    logic [7:0] bus, dout, q;
    ppp_pkg::ppp_strobe_s stb;
    int miscompares = 0, cmp_count = 0;
    initial forever #2.5 clk = ~clk;
    ppp_writer i_wr (.clk, .dev_o(dout), .dev_oe(doe), .busy, .vpp, .addr, .bus, .stb);
    ppp_prom_port i_dut (.clk, .reset, .reset_pin_n(rp_n), .mode_select_pin(vpp), .low_address_port(addr[7:0]),
        .high_address_port(addr[13:8]), .prom_data_port_i(bus), .prom_data_port_o(dout),
        .prom_data_port_oe(doe), .strobe_port(stb), .prog_mode(mode), .prog_busy(busy));
    task automatic chk(input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic rdc(input logic [13:0] a, input logic [7:0] e);
        i_wr.rd(a, 3'b001, q, oe);
        chk(q, e);
    endtask : rdc
    task automatic wrc(input logic [13:0] a, input logic [7:0] d, input logic v);
        i_wr.wr(a, d, v, ok);
        chk(8'(ok), 8'(v));
        if (v && ok !== 1'b1) final_report();
    endtask : wrc
    task automatic t_mode();
        rp_n = 1'b1;
        i_wr.rd(14'h1800, 3'b001, q, oe);
        chk({6'h00, mode, oe}, 8'h00);
        rp_n = 1'b0;
        for (int s = 2; s < 8; s++) begin
            i_wr.rd(14'h2A55, 3'(s), q, oe);
            chk({6'h00, mode, oe}, 8'h02);
        end
        $display("mode test done");
    endtask : t_mode
    task automatic t_write();
        rdc(14'h2A55, 8'hFF);
        wrc(14'h2A55, 8'hA5, 1'b1);
        rdc(14'h2A55, 8'hA5);
        rdc(14'h1A55, 8'hFF);
        rdc(14'h2A54, 8'hFF);
        wrc(14'h2A55, 8'h5A, 1'b1);
        rdc(14'h2A55, 8'h00);
        wrc(14'h17FF, 8'h00, 1'b1);
        rdc(14'h17FF, 8'h00);
        wrc(14'h3FFF, 8'h3C, 1'b0);
        rdc(14'h3FFF, 8'hFF);
        $display("write test done");
    endtask : t_write
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        t_mode();
        t_write();
        final_report();
    end
endmodule : tb_prom_programming_port
